// >>> dv/host_model.sv
`default_nettype none
module host_model (
    input  wire logic               i_link_clock,
    input  wire logic               i_ready,
    input  wire logic               i_rsp_valid,
    input  wire mpcfg_pkg::cmd_rsp_t i_rsp,
    output var  mpcfg_pkg::cmd_req_t o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    import mpcfg_pkg::*;
    //////////////////////////////////////////////////////////////////////////////////
    // one request at a time; idle fields show the inverse so stale data never matches
    initial o_cmd = '{1'b0, 1'b0, 8'hFF, 16'hFFFF};
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output cmd_rsp_t r, output logic ok);
        int n;
        ok = 1'b0;
        r  = '0;
        @(posedge i_link_clock);
        while (i_ready !== 1'b1)
            @(posedge i_link_clock);
        o_cmd <= '{1'b1, w, c, d};
        @(posedge i_link_clock);
        o_cmd <= '{1'b0, ~w, ~c, ~d};
        // answer within a bounded count of link cycles
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(posedge i_link_clock);
            if (i_rsp_valid === 1'b1)
            begin
                r  = i_rsp;
                ok = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> dv/multiphase_share_pgood_config_tb.sv
`default_nettype none
module multiphase_share_pgood_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mpcfg_pkg::*;
    logic i_clock = 0, lk = 0, rstn = 0, wp = 0, above = 0, sd = 0, idrv = 0;
    logic [2:0] offs = 0, p0, p1;
    cmd_req_t cmd;
    cmd_rsp_t rsp;
    logic ready, rv, pg, mm, ad, so, fu, hs, ls, de;
    logic [7:0] gain;
    logic [15:0] ind;
    share_cfg_t sc;
    int err_total = 0, n_checks = 0, c, k, e0;
    always #25 i_clock = ~i_clock;
    always #16 lk = ~lk;
    host_model i_host_model (.i_link_clock(lk), .i_ready(ready), .i_rsp_valid(rv),
        .i_rsp(rsp), .o_cmd(cmd));
    multiphase_share_pgood_config i_multiphase_share_pgood_config (.i_clock(i_clock),
        .i_rstn(rstn), .i_link_clock(lk), .i_cmd(cmd), .o_cmd_ready(ready), .o_rsp_valid(rv),
        .o_rsp(rsp), .i_write_protect(wp), .i_addr_strap(5'h0B), .i_phase_offset(offs),
        .i_above_pgood_on(above), .i_shutdown(sd), .i_integrated_driver(idrv),
        .o_pgood_pin(pg), .o_phase0(p0), .o_phase1(p1), .o_multiphase_mode(mm),
        .o_adaptive_loop_en(ad), .o_softoff_allowed(so), .o_fall_time_used(fu),
        .o_high_side_off(hs), .o_low_side_off(ls), .o_driver_enable(de),
        .o_ramp_gain(gain), .o_inductance_value(ind), .o_share_config(sc));
    //////////////////////////////////////////////////////////////////////////////////
    // compare, count and report
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] cd, input logic [15:0] d,
                       input logic rf, input logic [15:0] e);
        cmd_rsp_t r;
        logic ok;
        i_host_model.xfer(w, cd, d, r, ok);
        chk({15'h0, ok & (r.refused === rf)}, 16'h1);
        if (!w)
            chk(r.rdata, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #1200000;
        err_total++;
        conclude();
    end
    //////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial
    begin
        cyc(5);
        rstn <= 1'b1;
        cyc(10);
        acc(0, CMD_SHARE_CONFIG, 0, 0, 16'h0B00);
        acc(0, CMD_PGOOD_DELAY, 0, 0, 16'hCA00);
        acc(0, CMD_RAMP_GAIN, 0, 0, 16'h0003);
        acc(0, CMD_INDUCTANCE, 0, 0, 16'hB23D);
        acc(0, 8'hD7, 0, 1, 16'h0000);
        $display("reset values done");
        wp <= 1'b1;
        acc(1, CMD_RAMP_GAIN, 16'h00FF, 1, 0);
        wp <= 1'b0;
        acc(0, CMD_RAMP_GAIN, 0, 0, 16'h0003);
        acc(1, CMD_RAMP_GAIN, 16'h00FF, 0, 0);
        acc(1, CMD_INDUCTANCE, 16'h0C80, 0, 0);
        acc(0, CMD_INDUCTANCE, 0, 0, 16'h0C80);
        cyc(4);
        chk({gain, 8'h00}, 16'hFF00);
        chk(ind, 16'h0C80);
        $display("access done");
        // every shared count and id; unused bits written as ones
        for (c = 3; c <= 7; c += 2)
            for (k = 0; k <= c / 2; k++)
            begin
                acc(1, CMD_SHARE_CONFIG, {k[2:0], 5'h0B, 5'h1F, c[2:0]}, 0, 0);
                acc(0, CMD_SHARE_CONFIG, 0, 0, {k[2:0], 5'h0B, 5'h00, c[2:0]});
                chk(sc, {k[2:0], 5'h0B, 5'h00, c[2:0]});
                offs <= 3'(k + 1);
                cyc(4);
                e0 = (c == 3) ? 2 * k : k;
                chk({13'h0, p0}, 16'(e0));
                chk({13'h0, p1}, 16'(e0 + 4));
                chk({12'h0, mm, ad, so, fu}, 16'h0008);
            end
        $display("phase table done");
        acc(1, CMD_PGOOD_DELAY, 16'h0001, 0, 0); // one millisecond debounce
        @(posedge i_clock) above <= 1'b1;
        cyc(20003);
        chk({14'h0, pg, ad}, 16'h0);
        cyc(1);
        chk({14'h0, pg, ad}, 16'h2);
        cyc(1);
        chk({14'h0, pg, ad}, 16'h3);
        sd <= 1'b1;
        cyc(3);
        chk({13'h0, hs, ls, de}, 16'h7);
        idrv <= 1'b1;
        cyc(3);
        chk({13'h0, hs, ls, de}, 16'h0);
        $display("power good done");
        offs <= 3'h0;
        above <= 1'b0;
        acc(1, CMD_SHARE_CONFIG, 16'h0001, 0, 0);
        cyc(4);
        chk({6'h0, p0, p1, mm, ad, so, fu}, 16'h0047);
        $display("standalone done");
        conclude();
    end
endmodule
`default_nettype wire

// >>> verilog/cmd_crossing.sv
`default_nettype none
module cmd_crossing (
    input  wire logic                 i_clock,
    input  wire logic                 i_rstn,
    input  wire logic                 i_link_clock,
    input  wire mpcfg_pkg::cmd_req_t  i_link_cmd,
    output logic                      o_link_ready,
    output logic                      o_link_rsp_valid,
    output mpcfg_pkg::cmd_rsp_t       o_link_rsp,
    output mpcfg_pkg::cmd_req_t       o_core_req,
    input  wire logic                 i_core_done,
    input  wire mpcfg_pkg::cmd_rsp_t  i_core_rsp
);
    import mpcfg_pkg::*;

    typedef struct packed {
        logic     busy;
        logic     req_tgl;
        cmd_req_t held;
        logic     ack_meta;
        logic     ack_sync;
        logic     ack_seen;
        logic     rsp_valid;
        cmd_rsp_t rsp;
    } link_t;

    typedef struct packed {
        logic     req_meta;
        logic     req_sync;
        logic     req_seen;
        logic     ack_tgl;
        cmd_req_t req;
    } core_t;

    link_t      lk;
    link_t      next_lk;
    core_t      cr;
    core_t      next_cr;
    logic [1:0] link_rst;

    ////////////////////////////////////////////////////////////////////
    // link side reset release through two flops
    always_ff @(posedge i_link_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            link_rst <= 2'b00;
        else
            link_rst <= {link_rst[0], 1'b1};
    end

    // link side: hold the request, toggle it across, wait for the ack toggle
    always_comb
    begin
        next_lk           = lk;
        next_lk.ack_meta  = cr.ack_tgl;
        next_lk.ack_sync  = lk.ack_meta;
        next_lk.ack_seen  = lk.ack_sync;
        next_lk.rsp_valid = 1'b0;
        if (!lk.busy && i_link_cmd.valid)
        begin
            next_lk.held    = i_link_cmd;
            next_lk.req_tgl = ~lk.req_tgl;
            next_lk.busy    = 1'b1;
        end
        if (lk.busy && (lk.ack_sync != lk.ack_seen))
        begin
            next_lk.busy      = 1'b0;
            next_lk.rsp_valid = 1'b1;
            next_lk.rsp       = i_core_rsp;                         // held stable by core
        end
    end

    always_ff @(posedge i_link_clock or negedge link_rst[1])
    begin
        if (!link_rst[1])
            lk <= '0;
        else
            lk <= next_lk;
    end

    // core side: one-cycle request on each toggle edge, ack on done
    always_comb
    begin
        next_cr           = cr;
        next_cr.req_meta  = lk.req_tgl;
        next_cr.req_sync  = cr.req_meta;
        next_cr.req_seen  = cr.req_sync;
        next_cr.req.valid = 1'b0;
        if (cr.req_sync != cr.req_seen)
        begin
            next_cr.req       = lk.held;                            // stable while busy
            next_cr.req.valid = 1'b1;
        end
        if (i_core_done)
            next_cr.ack_tgl = ~cr.ack_tgl;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            cr <= '0;
        else
            cr <= next_cr;
    end

    assign o_link_ready     = ~lk.busy;
    assign o_link_rsp_valid = lk.rsp_valid;
    assign o_link_rsp       = lk.rsp;
    assign o_core_req       = cr.req;

endmodule
`default_nettype wire

// >>> verilog/mpcfg_pkg.sv
`default_nettype none
package mpcfg_pkg;

    // command codes of the four configuration words
    localparam logic [7:0]  CMD_SHARE_CONFIG = 8'hD3;
    localparam logic [7:0]  CMD_PGOOD_DELAY  = 8'hD4;
    localparam logic [7:0]  CMD_RAMP_GAIN    = 8'hD5;
    localparam logic [7:0]  CMD_INDUCTANCE   = 8'hD6;

    // reset values
    localparam logic [15:0] RST_PGOOD_DELAY  = 16'hCA00;
    localparam logic [7:0]  RST_RAMP_GAIN    = 8'h03;
    localparam logic [15:0] RST_INDUCTANCE   = 16'hB23D;
    localparam logic [2:0]  RST_PHASE_ID     = 3'h0;
    localparam logic [2:0]  RST_COUNT_M1     = 3'h0;

    // field positions of the sharing word
    localparam int          PHASE_ID_LSB     = 13;
    localparam int          RAIL_ID_LSB      = 8;
    localparam int          COUNT_LSB        = 0;

    // second phase sits half a switching period after the first
    localparam logic [2:0]  PHASE_HALF       = 3'h4;

    // timing: core clock period and delay step, both in ns
    localparam int          CLOCK_NS         = 50;
    localparam int          TICK_NS          = 125;
    localparam int          NS_PER_MS        = 1000000;
    localparam int          TICKS_PER_MS     = NS_PER_MS / TICK_NS;
    localparam int          STRAP_SETTLE     = 2;

    // sharing configuration word
    typedef struct packed {
        logic [2:0] phase_id;
        logic [4:0] rail_id;
        logic [4:0] unused;
        logic [2:0] count_m1;
    } share_cfg_t;

    // management bus request and answer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } cmd_req_t;

    typedef struct packed {
        logic        refused;
        logic [15:0] rdata;
    } cmd_rsp_t;

    // rail shares current when it has four, six or eight phases
    function automatic logic is_shared(input logic [2:0] count_m1);
        is_shared = (count_m1 == 3'h3) || (count_m1 == 3'h5) || (count_m1 == 3'h7);
    endfunction

    // linear-11 word to a count of delay steps, saturating at 32 bits
    function automatic logic [31:0] linear11_to_ticks(input logic [15:0] word);
        logic signed [4:0]  expo;
        logic signed [10:0] mant;
        logic [47:0]        prod;
        logic [47:0]        shifted;
        expo    = word[15:11];
        mant    = word[10:0];
        prod    = 48'(mant[9:0]) * 48'(TICKS_PER_MS);
        shifted = 48'h0;
        if (mant[10])
            shifted = 48'h0;
        else if (!expo[4])
            shifted = prod << expo[3:0];
        else
            shifted = prod >> (5'(~expo) + 5'h1);      // magnitude of the exponent, up to 16
        linear11_to_ticks = (shifted[47:32] != 16'h0) ? 32'hFFFFFFFF : shifted[31:0];
    endfunction

endpackage
`default_nettype wire

// >>> verilog/multiphase_share_pgood_config.sv
// Operation
// - shared rail members get phase offsets from their phase id
// - offset command only moves non-sharing rails
// - single two-phase device uses positions 0, 4
// - id k: k,k+4; four-phase: 2k, 2k+4
// - sharing word: id, rail, unused fields
// - low three bits hold phase count minus one
// - power good waits programmed delay, 125 ns steps
// - delay word resets to CA00h
// - multiphase ramp mode for 4, 6, 8 phases
// - fast loop off on ramp, on after pgood
// - multiphase mode: no soft-off, fall time ignored
// - multiphase shutdown: both switches off, or driver disabled when integrated
// - two phases: fast loop always, normal turn-off
// - ramp gain eight bits, resets to 03h
// - inductance word stored, resets to B23Dh
// - words readable, writable, honour write protection
`default_nettype none
module multiphase_share_pgood_config (
    input  wire logic                 i_clock,
    input  wire logic                 i_rstn,
    input  wire logic                 i_link_clock,
    input  wire mpcfg_pkg::cmd_req_t  i_cmd,
    output logic                      o_cmd_ready,
    output logic                      o_rsp_valid,
    output mpcfg_pkg::cmd_rsp_t       o_rsp,
    input  wire logic                 i_write_protect,
    input  wire logic [4:0]           i_addr_strap,
    input  wire logic [2:0]           i_phase_offset,
    input  wire logic                 i_above_pgood_on,
    input  wire logic                 i_shutdown,
    input  wire logic                 i_integrated_driver,
    output logic                      o_pgood_pin,
    output logic [2:0]                o_phase0,
    output logic [2:0]                o_phase1,
    output logic                      o_multiphase_mode,
    output logic                      o_adaptive_loop_en,
    output logic                      o_softoff_allowed,
    output logic                      o_fall_time_used,
    output logic                      o_high_side_off,
    output logic                      o_low_side_off,
    output logic                      o_driver_enable,
    output logic [7:0]                o_ramp_gain,
    output logic [15:0]               o_inductance_value,
    output mpcfg_pkg::share_cfg_t     o_share_config
);
    import mpcfg_pkg::*;

    typedef struct packed {
        logic [4:0]  strap_meta;
        logic [4:0]  strap_sync;
        logic [1:0]  strap_age;
        logic        above_meta;
        logic        above_sync;
        share_cfg_t  share;
        logic [15:0] pgood_delay;
        logic [7:0]  gain;
        logic [15:0] inductance;
        logic        done;
        cmd_rsp_t    rsp;
        logic [2:0]  phase0;
        logic [2:0]  phase1;
        logic        multiphase;
        logic        adaptive;
        logic        softoff;
        logic        fall_used;
        logic        hs_off;
        logic        ls_off;
        logic        drv_en;
    } top_t;

    localparam top_t RESET_STATE = '{
        strap_meta:  5'h00,
        strap_sync:  5'h00,
        strap_age:   2'h0,
        above_meta:  1'b0,
        above_sync:  1'b0,
        share:       '{phase_id: RST_PHASE_ID, rail_id: 5'h00,
                       unused: 5'h00, count_m1: RST_COUNT_M1},
        pgood_delay: RST_PGOOD_DELAY,
        gain:        RST_RAMP_GAIN,
        inductance:  RST_INDUCTANCE,
        done:        1'b0,
        rsp:         '{refused: 1'b0, rdata: 16'h0000},
        phase0:      3'h0,
        phase1:      PHASE_HALF,
        multiphase:  1'b0,
        adaptive:    1'b1,
        softoff:     1'b1,
        fall_used:   1'b1,
        hs_off:      1'b0,
        ls_off:      1'b0,
        drv_en:      1'b1
    };

    top_t       st;
    top_t       next_st;
    logic [1:0] rst_ff;
    logic       rst_n;
    cmd_req_t   core_req;
    logic       pgood;
    logic       shared;
    logic       mapped;

    ////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            rst_ff <= 2'b00;
        else
            rst_ff <= {rst_ff[0], 1'b1};
    end

    assign rst_n = rst_ff[1];

    ////////////////////////////////////////////////////////////////////
    // management bus requests cross from the link clock
    cmd_crossing u_crossing (
        .i_clock          (i_clock),
        .i_rstn           (rst_n),
        .i_link_clock     (i_link_clock),
        .i_link_cmd       (i_cmd),
        .o_link_ready     (o_cmd_ready),
        .o_link_rsp_valid (o_rsp_valid),
        .o_link_rsp       (o_rsp),
        .o_core_req       (core_req),
        .i_core_done      (st.done),
        .i_core_rsp       (st.rsp)
    );

    // power good delay timer on the synchronised comparator
    pgood_timer u_pgood (
        .i_clock      (i_clock),
        .i_rstn       (rst_n),
        .i_above      (st.above_sync),
        .i_delay_word (st.pgood_delay),
        .o_pgood      (pgood)
    );

    ////////////////////////////////////////////////////////////////////
    // register file, strap load and derived phase and ramp controls
    always_comb
    begin
        next_st            = st;
        shared             = is_shared(st.share.count_m1);
        mapped             = (core_req.code == CMD_SHARE_CONFIG) ||
                             (core_req.code == CMD_PGOOD_DELAY)  ||
                             (core_req.code == CMD_RAMP_GAIN)    ||
                             (core_req.code == CMD_INDUCTANCE);
        next_st.strap_meta = i_addr_strap;
        next_st.strap_sync = st.strap_meta;
        next_st.above_meta = i_above_pgood_on;
        next_st.above_sync = st.above_meta;
        next_st.done       = 1'b0;

        // strap supplies the rail id once it has settled after release
        if (st.strap_age != 2'(STRAP_SETTLE + 1))
            next_st.strap_age = st.strap_age + 2'h1;
        if (st.strap_age == 2'(STRAP_SETTLE))
            next_st.share.rail_id = st.strap_sync;

        // command handling; answer stands one cycle later
        if (core_req.valid)
        begin
            next_st.done        = 1'b1;
            next_st.rsp.refused = !mapped || (core_req.write && i_write_protect);
            next_st.rsp.rdata   = 16'h0000;
            if (core_req.write && mapped && !i_write_protect)
            begin
                unique case (core_req.code)
                    CMD_SHARE_CONFIG:
                    begin
                        next_st.share.phase_id = core_req.wdata[PHASE_ID_LSB +: 3];
                        next_st.share.rail_id  = core_req.wdata[RAIL_ID_LSB +: 5];
                        next_st.share.unused   = 5'h00;
                        next_st.share.count_m1 = core_req.wdata[COUNT_LSB +: 3];
                    end
                    CMD_PGOOD_DELAY:
                        next_st.pgood_delay = core_req.wdata;
                    CMD_RAMP_GAIN:
                        next_st.gain = core_req.wdata[7:0];
                    CMD_INDUCTANCE:
                        next_st.inductance = core_req.wdata;
                    default:
                        next_st.gain = st.gain;
                endcase
            end
            else if (!core_req.write)
            begin
                unique case (core_req.code)
                    CMD_SHARE_CONFIG: next_st.rsp.rdata = st.share;
                    CMD_PGOOD_DELAY:  next_st.rsp.rdata = st.pgood_delay;
                    CMD_RAMP_GAIN:    next_st.rsp.rdata = {8'h00, st.gain};
                    CMD_INDUCTANCE:   next_st.rsp.rdata = st.inductance;
                    default:          next_st.rsp.rdata = 16'h0000;
                endcase
            end
        end

        // phase positions from the sharing word only on shared rails
        if (shared && st.share.count_m1 == 3'h3)
        begin
            next_st.phase0 = 3'(st.share.phase_id << 1);
            next_st.phase1 = 3'(st.share.phase_id << 1) + PHASE_HALF;
        end
        else if (shared)
        begin
            next_st.phase0 = st.share.phase_id;
            next_st.phase1 = st.share.phase_id + PHASE_HALF;
        end
        else
        begin
            next_st.phase0 = i_phase_offset;
            next_st.phase1 = i_phase_offset + PHASE_HALF;
        end

        // multiphase ramp mode and the turn-on and turn-off behaviour
        next_st.multiphase = shared;
        next_st.adaptive   = !shared || pgood;
        next_st.softoff    = !shared;
        next_st.fall_used  = !shared;
        next_st.hs_off     = shared && i_shutdown && !i_integrated_driver;
        next_st.ls_off     = shared && i_shutdown && !i_integrated_driver;
        next_st.drv_en     = !(shared && i_shutdown && i_integrated_driver);
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            st <= RESET_STATE;
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign o_pgood_pin        = pgood;
    assign o_phase0           = st.phase0;
    assign o_phase1           = st.phase1;
    assign o_multiphase_mode  = st.multiphase;
    assign o_adaptive_loop_en = st.adaptive;
    assign o_softoff_allowed  = st.softoff;
    assign o_fall_time_used   = st.fall_used;
    assign o_high_side_off    = st.hs_off;
    assign o_low_side_off     = st.ls_off;
    assign o_driver_enable    = st.drv_en;
    assign o_ramp_gain        = st.gain;
    assign o_inductance_value = st.inductance;
    assign o_share_config     = st.share;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);

    four_phase_a: assert property (
        st.share.count_m1 == 3'h3 |=> st.phase0 == 3'($past(st.share.phase_id) << 1)
                                   && st.phase1 == 3'($past(st.share.phase_id) << 1) + 3'h4)
        else $error("four phase positions wrong");

    wide_phase_a: assert property (
        (st.share.count_m1 == 3'h5 || st.share.count_m1 == 3'h7)
        |=> st.phase0 == $past(st.share.phase_id)
         && st.phase1 == $past(st.share.phase_id) + 3'h4)
        else $error("six or eight phase positions wrong");

    alone_phase_a: assert property (
        !is_shared(st.share.count_m1)
        |=> st.phase0 == $past(i_phase_offset) && st.phase1 == $past(i_phase_offset) + 3'h4)
        else $error("standalone positions wrong");

    ramp_mode_a: assert property (
        is_shared(st.share.count_m1) |=> o_multiphase_mode && !o_softoff_allowed)
        else $error("multiphase ramp mode not entered");

    fast_loop_a: assert property (
        o_adaptive_loop_en == $past(!is_shared(st.share.count_m1) || pgood))
        else $error("fast loop enable wrong");

    turnoff_mode_a: assert property (
        o_multiphase_mode |-> !o_softoff_allowed && !o_fall_time_used && o_adaptive_loop_en
                              == $past(pgood))
        else $error("turn-off controls wrong in ramp mode");

    shutdown_drv_a: assert property (
        is_shared(st.share.count_m1) && i_shutdown
        |=> (o_driver_enable == !$past(i_integrated_driver))
         && (o_high_side_off == !$past(i_integrated_driver)) && o_low_side_off == o_high_side_off)
        else $error("multiphase shutdown outputs wrong");

    protect_hold_a: assert property (
        core_req.valid && core_req.write && i_write_protect
        |=> st.gain == $past(st.gain) && st.pgood_delay == $past(st.pgood_delay)
         && st.inductance == $past(st.inductance) && st.done && st.rsp.refused)
        else $error("protected write changed a word");

    reset_value_a: assert property (
        $rose(rst_n) |-> st.pgood_delay == 16'hCA00 && st.gain == 8'h03
                      && st.inductance == 16'hB23D)
        else $error("reset values wrong");

    share_write_a: assert property (
        core_req.valid && core_req.write && core_req.code == 8'hD3 && !i_write_protect
        |=> st.share == {$past(core_req.wdata[15:8]), 5'h00, $past(core_req.wdata[2:0])})
        else $error("share word not stored");

    unmapped_refuse_a: assert property (
        core_req.valid
        && !(core_req.code inside {8'hD3, 8'hD4, 8'hD5, 8'hD6})
        |=> st.done && st.rsp.refused && st.rsp.rdata == 16'h0000)
        else $error("unmapped command not refused");

    delay_read_a: assert property (
        core_req.valid && !core_req.write && core_req.code == 8'hD4
        |=> !st.rsp.refused && st.rsp.rdata == $past(st.pgood_delay))
        else $error("delay read wrong");

    gain_write_a: assert property (
        core_req.valid && core_req.write && core_req.code == 8'hD5 && !i_write_protect
        |=> o_ramp_gain == $past(core_req.wdata[7:0]))
        else $error("gain not stored");

    inductance_write_a: assert property (
        core_req.valid && core_req.write && core_req.code == 8'hD6 && !i_write_protect
        |=> o_inductance_value == $past(core_req.wdata))
        else $error("inductance not stored");

    strap_load_a: assert property (
        st.strap_age == 2'h2 && !core_req.valid |=> st.share.rail_id == $past(st.strap_sync))
        else $error("rail id not from strap");

    two_phase_a: assert property (
        !is_shared(st.share.count_m1)
        |=> o_adaptive_loop_en && o_softoff_allowed && o_fall_time_used && !o_multiphase_mode)
        else $error("standalone controls wrong");

    phase_gap_a: assert property (
        o_phase1 == o_phase0 + 3'h4)
        else $error("phase gap wrong");

endmodule
`default_nettype wire

// >>> verilog/pgood_timer.sv
`default_nettype none
module pgood_timer (
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_above,
    input  wire logic [15:0] i_delay_word,
    output logic             o_pgood
);
    import mpcfg_pkg::*;

    typedef enum logic [1:0] {
        PG_LOW   = 2'b00,
        PG_DELAY = 2'b01,
        PG_HIGH  = 2'b10
    } pg_state_t;

    typedef struct packed {
        pg_state_t   state;
        logic [7:0]  frac_ns;
        logic [31:0] ticks;
        logic        pgood;
    } timer_t;

    timer_t st;
    timer_t next_st;
    logic [31:0] target;

    ////////////////////////////////////////////////////////////////////
    // delay in 125 ns steps; fractional accumulator spreads 50 ns clocks
    always_comb
    begin
        target  = linear11_to_ticks(i_delay_word);
        next_st = st;
        unique case (st.state)
            PG_LOW:
            begin
                next_st.pgood   = 1'b0;
                next_st.frac_ns = 8'h00;
                next_st.ticks   = 32'h0;
                if (i_above)
                    next_st.state = PG_DELAY;
            end
            PG_DELAY:
            begin
                if (!i_above)
                    next_st.state = PG_LOW;
                else if (st.ticks >= target)
                begin
                    next_st.state = PG_HIGH;
                    next_st.pgood = 1'b1;
                end
                else if (st.frac_ns + 8'(CLOCK_NS) >= 8'(TICK_NS))
                begin
                    next_st.frac_ns = st.frac_ns + 8'(CLOCK_NS) - 8'(TICK_NS);
                    next_st.ticks   = st.ticks + 32'h1;
                end
                else
                    next_st.frac_ns = st.frac_ns + 8'(CLOCK_NS);
            end
            PG_HIGH:
            begin
                if (!i_above)
                begin
                    next_st.state = PG_LOW;
                    next_st.pgood = 1'b0;
                end
            end
            default:
                next_st.state = PG_LOW;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            st <= '{state: PG_LOW, frac_ns: 8'h00, ticks: 32'h0, pgood: 1'b0};
        else
            st <= next_st;
    end

    assign o_pgood = st.pgood;

    pgood_cause_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        $rose(o_pgood) |-> $past(i_above) && $past(st.state) == PG_DELAY)
        else $error("power good rose without the delay running");

endmodule
`default_nettype wire
